// ---- hw/mcrb_pkg.sv ----
package mcrb_pkg;
   // ***********************************************************
   // Register offsets (serial control port addresses)
   // ***********************************************************
   localparam logic [7:0] ADDR_ANALOG_POWERDOWN_CTRL = 8'h43;
   localparam logic [7:0] ADDR_PIN_DRIVE_CTRL        = 8'h47;
   localparam logic [7:0] ADDR_DOMAIN_CROSSING_CTRL  = 8'h4b;
   localparam logic [7:0] ADDR_AUX_PIN0_SOURCE       = 8'h50;
   localparam logic [7:0] ADDR_AUX_PIN1_SOURCE       = 8'h51;
   localparam logic [7:0] ADDR_AUX_PAIR_SOURCE       = 8'h52;
   localparam logic [7:0] ADDR_CLOCK_WATCH_STATUS    = 8'h54;
   localparam logic [7:0] ADDR_CLOCK_WATCH_FLAGS     = 8'h55;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [7:0] RST_ANALOG_POWERDOWN_CTRL = 8'h03;
   localparam logic [7:0] RST_PIN_DRIVE_CTRL        = 8'h2a;
   localparam logic [7:0] RST_DOMAIN_CROSSING_CTRL  = 8'h00;
   localparam logic [7:0] RST_AUX_PIN0_SOURCE       = 8'h15;
   localparam logic [7:0] RST_AUX_PIN1_SOURCE       = 8'h15;
   localparam logic [7:0] RST_AUX_PAIR_SOURCE       = 8'h00;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int BIT_ANALOG_POWERDOWN      = 0;
   localparam int BIT_GATE_POWERDOWN_SELECT = 1;
   localparam int BIT_CROSSING_SOFT_RESET   = 7;
   localparam int LSB_CROSSING_RATIO        = 0;
   localparam int LSB_SERIAL_OUT_DRIVE      = 0;
   localparam int LSB_AUX_PIN_DRIVE         = 2;
   localparam int LSB_AUX_PIN_DIR           = 4;
   localparam int BIT_CLOCK_WATCH_HALT      = 7;
   localparam int BIT_RECOVERED_IDLE        = 5;
   localparam int BIT_LANE_ALIGN_SEEN       = 4;
   localparam int LSB_CLOCK_WATCH_VALUE     = 0;

   localparam logic [7:0] MASK_ANALOG_POWERDOWN_CTRL = 8'h03;
   localparam logic [7:0] MASK_PIN_DRIVE_CTRL        = 8'h3f;
   localparam logic [7:0] MASK_DOMAIN_CROSSING_CTRL  = 8'h83;
   localparam logic [7:0] DATA_ZERO                  = 8'h00;

   // ***********************************************************
   // Enumerations
   // ***********************************************************
   typedef enum logic [1:0] {
      MCRB_DRIVE_VLOW_NOISE = 2'h0,
      MCRB_DRIVE_MED_NOISE  = 2'h1,
      MCRB_DRIVE_LOW_NOISE  = 2'h2,
      MCRB_DRIVE_HIGH_NOISE = 2'h3
   } mcrb_drive_mode_t;

   typedef enum logic [1:0] {
      MCRB_RATIO_X2     = 2'h0,
      MCRB_RATIO_X4     = 2'h1,
      MCRB_RATIO_X8     = 2'h2,
      MCRB_RATIO_UNUSED = 2'h3
   } mcrb_ratio_t;

   // ***********************************************************
   // Carriers
   // ***********************************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mcrb_req_t;

   typedef struct packed {
      logic [3:0] slew;   // One-hot per mode: vlow, med, low, high
      logic [1:0] code;
   } mcrb_drive_t;

   typedef struct packed {
      logic       halt;
      logic       recovered_idle;
      logic       lane_align_seen;
      logic [3:0] value;
      logic [7:0] flag_bits;
   } mcrb_mon_t;
endpackage : mcrb_pkg

// ---- hw/mcrb_drive_decode.sv ----
`timescale 1ns/10ps
module mcrb_drive_decode
   import mcrb_pkg::*;
(
   input  wire logic                        clk_in,
   input  wire logic                        srst_in,
   input  wire logic [1:0]                  drive_mode_in,
   output mcrb_pkg::mcrb_drive_t            drive_out
);
   import mcrb_pkg::*;

   mcrb_drive_t drive;
   mcrb_drive_t next_drive;

   // ***********************************************************
   // Drive mode decode
   // ***********************************************************
   always_comb
   begin
      next_drive.code = drive_mode_in;
      case (mcrb_drive_mode_t'(drive_mode_in)) // R06
         MCRB_DRIVE_VLOW_NOISE: next_drive.slew = 4'h1;
         MCRB_DRIVE_MED_NOISE:  next_drive.slew = 4'h2;
         MCRB_DRIVE_LOW_NOISE:  next_drive.slew = 4'h4;
         MCRB_DRIVE_HIGH_NOISE: next_drive.slew = 4'h8;
         default:               next_drive.slew = 4'h4;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         drive <= '{slew: 4'h4, code: MCRB_DRIVE_LOW_NOISE};
      end
      else
      begin
         drive <= next_drive;
      end
   end

   assign drive_out = drive;
endmodule : mcrb_drive_decode

// ---- hw/mcrb_main.sv ----
// Contract
// R01: Gate-powerdown select bit lets transmit gate pin trigger analog power down.
// R02: Analog powerdown bit one powers down analog except clocks; zero does nothing.
// R03: Aux pin direction bits 5:4, one input, zero output, default 10.
// R04: Aux pin drive field bits 3:2 sets aux drive mode, default 10.
// R05: Serial out drive field bits 1:0 sets serial pin drive, default 10.
// R06: Drive codes: 00 very low noise, 01 medium, 10 low, 11 high.
// R07: Writing one to soft reset bit 7 resets crossing logic; zero no action.
// R08: Ratio field 00 x2, 01 x4, 10 x8; software never writes 11.
// R09: Two source registers select internal signal for aux pin 0 and 1.
// R10: Third source register selects joint routing for the aux pin pair.
// R11: Status bit 7 reports clock watch halt indication.
// R12: Status bit 5 flags recovered clock idle.
// R13: Status bit 4 flags lane alignment sequence received.
// R14: Status bits 3:0 return the clock watch value.
// R15: Flags register returns eight clock watch flag bits.
// R16: Monitor registers hold undefined contents after power up and reset.
`timescale 1ns/10ps
module mcrb_main
   import mcrb_pkg::*;
(
   input  wire logic                        clk_in,
   input  wire logic                        srst_in,
   input  mcrb_pkg::mcrb_req_t              req_in,
   output logic [7:0]                       rdata_out,
   output logic                             rvalid_out,
   input  wire logic                        transmit_gate_pin_in,
   input  mcrb_pkg::mcrb_mon_t              mon_in,
   output logic                             analog_powerdown_out,
   output logic [1:0]                       aux_pin_dir_out,
   output mcrb_pkg::mcrb_drive_t            aux_pin_drive_out,
   output mcrb_pkg::mcrb_drive_t            serial_out_drive_out,
   output logic                             crossing_soft_reset_out,
   output mcrb_pkg::mcrb_ratio_t            crossing_ratio_out,
   output logic [7:0]                       aux_pin0_sel_out,
   output logic [7:0]                       aux_pin1_sel_out,
   output logic [7:0]                       aux_pair_sel_out
);
   import mcrb_pkg::*;

   // ***********************************************************
   // Register state
   // ***********************************************************
   logic [7:0] analog_powerdown_ctrl;
   logic [7:0] pin_drive_ctrl;
   logic [7:0] domain_crossing_ctrl;
   logic [7:0] aux_pin0_source;
   logic [7:0] aux_pin1_source;
   logic [7:0] aux_pair_source;
   logic [7:0] next_analog_powerdown_ctrl;
   logic [7:0] next_pin_drive_ctrl;
   logic [7:0] next_domain_crossing_ctrl;
   logic [7:0] next_aux_pin0_source;
   logic [7:0] next_aux_pin1_source;
   logic [7:0] next_aux_pair_source;
   logic       soft_reset_pulse;
   logic       next_soft_reset_pulse;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic       rvalid;
   logic       next_rvalid;
   logic       gate_meta;
   logic       gate_sync;
   logic       powerdown;
   logic       next_powerdown;
   logic [7:0] mon_status;
   logic [7:0] mon_flags;
   logic [1:0]  drive_field [2];
   mcrb_drive_t drive_word  [2];

   function automatic logic hit(input mcrb_req_t r, input logic [7:0] a);
      hit = r.wr && (r.addr == a);
   endfunction : hit

   // ***********************************************************
   // Transmit gate pin synchroniser
   // ***********************************************************
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         gate_meta <= 1'b0;
         gate_sync <= 1'b0;
      end
      else
      begin
         gate_meta <= transmit_gate_pin_in;
         gate_sync <= gate_meta;
      end
   end

   // ***********************************************************
   // Power down register writes
   // ***********************************************************
   always_comb
   begin
      next_analog_powerdown_ctrl = analog_powerdown_ctrl;
      if (hit(req_in, ADDR_ANALOG_POWERDOWN_CTRL))
      begin
         next_analog_powerdown_ctrl = req_in.wdata & MASK_ANALOG_POWERDOWN_CTRL; // R01 R02
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         analog_powerdown_ctrl <= RST_ANALOG_POWERDOWN_CTRL;
      end
      else
      begin
         analog_powerdown_ctrl <= next_analog_powerdown_ctrl;
      end
   end

   // ***********************************************************
   // Pin drive register writes
   // ***********************************************************
   always_comb
   begin
      next_pin_drive_ctrl = pin_drive_ctrl;
      if (hit(req_in, ADDR_PIN_DRIVE_CTRL))
      begin
         next_pin_drive_ctrl = req_in.wdata & MASK_PIN_DRIVE_CTRL; // R03 R04 R05
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pin_drive_ctrl <= RST_PIN_DRIVE_CTRL; // R03 R04 R05
      end
      else
      begin
         pin_drive_ctrl <= next_pin_drive_ctrl;
      end
   end

   // ***********************************************************
   // Crossing register writes
   // ***********************************************************
   always_comb
   begin
      next_domain_crossing_ctrl = domain_crossing_ctrl;
      if (hit(req_in, ADDR_DOMAIN_CROSSING_CTRL))
      begin
         next_domain_crossing_ctrl = req_in.wdata & MASK_DOMAIN_CROSSING_CTRL; // R08
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         domain_crossing_ctrl <= RST_DOMAIN_CROSSING_CTRL;
      end
      else
      begin
         domain_crossing_ctrl <= next_domain_crossing_ctrl;
      end
   end

   // ***********************************************************
   // Crossing soft reset pulse
   // ***********************************************************
   always_comb
   begin
      next_soft_reset_pulse = hit(req_in, ADDR_DOMAIN_CROSSING_CTRL)
                              && req_in.wdata[BIT_CROSSING_SOFT_RESET]; // R07
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         soft_reset_pulse <= 1'b0;
      end
      else
      begin
         soft_reset_pulse <= next_soft_reset_pulse;
      end
   end

   // ***********************************************************
   // Auxiliary pin source writes
   // ***********************************************************
   always_comb
   begin
      next_aux_pin0_source = aux_pin0_source;
      next_aux_pin1_source = aux_pin1_source;
      next_aux_pair_source = aux_pair_source;
      if (hit(req_in, ADDR_AUX_PIN0_SOURCE))
      begin
         next_aux_pin0_source = req_in.wdata; // R09
      end
      if (hit(req_in, ADDR_AUX_PIN1_SOURCE))
      begin
         next_aux_pin1_source = req_in.wdata; // R09
      end
      if (hit(req_in, ADDR_AUX_PAIR_SOURCE))
      begin
         next_aux_pair_source = req_in.wdata; // R10
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         aux_pin0_source <= RST_AUX_PIN0_SOURCE;
         aux_pin1_source <= RST_AUX_PIN1_SOURCE;
         aux_pair_source <= RST_AUX_PAIR_SOURCE;
      end
      else
      begin
         aux_pin0_source <= next_aux_pin0_source;
         aux_pin1_source <= next_aux_pin1_source;
         aux_pair_source <= next_aux_pair_source;
      end
   end

   // ***********************************************************
   // Power down control
   // ***********************************************************
   always_comb
   begin
      next_powerdown = analog_powerdown_ctrl[BIT_ANALOG_POWERDOWN]; // R02
      if (analog_powerdown_ctrl[BIT_GATE_POWERDOWN_SELECT] && gate_sync)
      begin
         next_powerdown = 1'b1; // R01
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         powerdown <= 1'b0;
      end
      else
      begin
         powerdown <= next_powerdown;
      end
   end

   // ***********************************************************
   // Drive mode decoders
   // ***********************************************************
   assign drive_field[0] = pin_drive_ctrl[LSB_AUX_PIN_DRIVE +: 2]; // R04
   assign drive_field[1] = pin_drive_ctrl[LSB_SERIAL_OUT_DRIVE +: 2]; // R05

   for (genvar g = 0; g < 2; g++)
   begin : g_drive
      mcrb_drive_decode u_drive ( // R06
         .clk_in        (clk_in),
         .srst_in       (srst_in),
         .drive_mode_in (drive_field[g]),
         .drive_out     (drive_word[g])
      );
   end

   // ***********************************************************
   // Monitor status, passed straight from the monitors
   // ***********************************************************
   always_comb
   begin
      mon_status = DATA_ZERO;
      mon_status[BIT_CLOCK_WATCH_HALT]            = mon_in.halt; // R11
      mon_status[BIT_RECOVERED_IDLE]              = mon_in.recovered_idle; // R12
      mon_status[BIT_LANE_ALIGN_SEEN]             = mon_in.lane_align_seen; // R13
      mon_status[LSB_CLOCK_WATCH_VALUE +: 4]      = mon_in.value; // R14
      mon_flags                                   = mon_in.flag_bits; // R15
   end

   // ***********************************************************
   // Register reads
   // ***********************************************************
   always_comb
   begin
      next_rvalid = req_in.rd;
      next_rdata  = rdata;
      if (req_in.rd)
      begin
         case (req_in.addr)
            ADDR_ANALOG_POWERDOWN_CTRL: next_rdata = analog_powerdown_ctrl;
            ADDR_PIN_DRIVE_CTRL:        next_rdata = pin_drive_ctrl;
            ADDR_DOMAIN_CROSSING_CTRL:  next_rdata = domain_crossing_ctrl;
            ADDR_AUX_PIN0_SOURCE:       next_rdata = aux_pin0_source;
            ADDR_AUX_PIN1_SOURCE:       next_rdata = aux_pin1_source;
            ADDR_AUX_PAIR_SOURCE:       next_rdata = aux_pair_source;
            ADDR_CLOCK_WATCH_STATUS:    next_rdata = mon_status; // R16
            ADDR_CLOCK_WATCH_FLAGS:     next_rdata = mon_flags; // R16
            default:                    next_rdata = DATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         rdata  <= DATA_ZERO;
         rvalid <= 1'b0;
      end
      else
      begin
         rdata  <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign rdata_out               = rdata;
   assign rvalid_out              = rvalid;
   assign analog_powerdown_out    = powerdown;
   assign aux_pin_dir_out         = pin_drive_ctrl[LSB_AUX_PIN_DIR +: 2]; // R03
   assign aux_pin_drive_out       = drive_word[0]; // R04
   assign serial_out_drive_out    = drive_word[1]; // R05
   assign crossing_soft_reset_out = soft_reset_pulse; // R07
   assign crossing_ratio_out      = mcrb_ratio_t'(domain_crossing_ctrl[LSB_CROSSING_RATIO +: 2]); // R08
   assign aux_pin0_sel_out        = aux_pin0_source;
   assign aux_pin1_sel_out        = aux_pin1_source;
   assign aux_pair_sel_out        = aux_pair_source;
endmodule : mcrb_main

// ---- bench/mcrb_main_props.sv ----
`timescale 1ns/10ps
module mcrb_main_props
   import mcrb_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   input  mcrb_pkg::mcrb_req_t    req_in,
   input  wire logic [7:0]        rdata_out,
   input  wire logic              rvalid_out,
   input  wire logic              transmit_gate_pin_in,
   input  mcrb_pkg::mcrb_mon_t    mon_in,
   input  wire logic              analog_powerdown_out,
   input  wire logic [1:0]        aux_pin_dir_out,
   input  mcrb_pkg::mcrb_drive_t  aux_pin_drive_out,
   input  mcrb_pkg::mcrb_drive_t  serial_out_drive_out,
   input  wire logic              crossing_soft_reset_out,
   input  mcrb_pkg::mcrb_ratio_t  crossing_ratio_out,
   input  wire logic [7:0]        aux_pin0_sel_out,
   input  wire logic [7:0]        aux_pin1_sel_out,
   input  wire logic [7:0]        aux_pair_sel_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   // ***********************************************************
   // Assertions
   // ***********************************************************
   a_pin0_write: assert property (
      req_in.wr && req_in.addr == 8'h50 |=> aux_pin0_sel_out == $past(req_in.wdata))
      else $error("aux pin 0 selector not updated");
   a_pin1_write: assert property (
      req_in.wr && req_in.addr == 8'h51 |=> aux_pin1_sel_out == $past(req_in.wdata))
      else $error("aux pin 1 selector not updated");
   a_pair_write: assert property (
      req_in.wr && req_in.addr == 8'h52 |=> aux_pair_sel_out == $past(req_in.wdata))
      else $error("aux pair selector not updated");
   a_ratio_write: assert property (
      req_in.wr && req_in.addr == 8'h4b |=> crossing_ratio_out == $past(req_in.wdata[1:0]))
      else $error("crossing ratio not updated");
   a_dir_write: assert property (
      req_in.wr && req_in.addr == 8'h47 |=> aux_pin_dir_out == $past(req_in.wdata[5:4]))
      else $error("aux pin direction not updated");
   a_soft_reset_pulse: assert property (
      req_in.wr && req_in.addr == 8'h4b && req_in.wdata[7] |=> crossing_soft_reset_out)
      else $error("soft reset pulse missing");
   a_soft_reset_quiet: assert property (
      !(req_in.wr && req_in.addr == 8'h4b && req_in.wdata[7]) |=> !crossing_soft_reset_out)
      else $error("soft reset pulse without cause");
   a_aux_slew_match: assert property (
      aux_pin_drive_out.slew == (4'h1 << aux_pin_drive_out.code))
      else $error("aux drive decode wrong");
   a_serial_slew_match: assert property (
      serial_out_drive_out.slew == (4'h1 << serial_out_drive_out.code))
      else $error("serial drive decode wrong");
   a_status_read: assert property (
      req_in.rd && req_in.addr == 8'h54 |=> rvalid_out && rdata_out[3:0] == $past(mon_in.value)
      && {rdata_out[7], rdata_out[5:4]} == $past({mon_in.halt, mon_in.recovered_idle,
      mon_in.lane_align_seen})) else $error("status read wrong");
   a_flags_read: assert property (
      req_in.rd && req_in.addr == 8'h55 |=> rvalid_out ##0 rdata_out == $past(mon_in.flag_bits))
      else $error("flags read wrong");

   c_soft_reset: cover property (crossing_soft_reset_out);
   c_gate_powerdown: cover property (transmit_gate_pin_in ##3 $rose(analog_powerdown_out));
   c_flags_read: cover property (req_in.rd && req_in.addr == 8'h55);
endmodule : mcrb_main_props

bind mcrb_main mcrb_main_props u_props (.clk_in(clk_in), .srst_in(srst_in), .req_in(req_in),
   .rdata_out(rdata_out), .rvalid_out(rvalid_out), .transmit_gate_pin_in(transmit_gate_pin_in),
   .mon_in(mon_in), .analog_powerdown_out(analog_powerdown_out),
   .aux_pin_dir_out(aux_pin_dir_out), .aux_pin_drive_out(aux_pin_drive_out),
   .serial_out_drive_out(serial_out_drive_out),
   .crossing_soft_reset_out(crossing_soft_reset_out), .crossing_ratio_out(crossing_ratio_out),
   .aux_pin0_sel_out(aux_pin0_sel_out), .aux_pin1_sel_out(aux_pin1_sel_out),
   .aux_pair_sel_out(aux_pair_sel_out));

// ---- bench/main_control_register_bank_test.sv ----
`timescale 1ns/10ps
module main_control_register_bank_test;
   import mcrb_pkg::*;
   logic        clk_in = 1'b0;
   logic        srst_in = 1'b1;
   mcrb_req_t   req = '0;
   mcrb_mon_t   mon = '0;
   logic        gate = 1'b0;
   logic [7:0]  rdata, s0, s1, sp, sel;
   logic        rvalid, apd, csr;
   logic [1:0]  dir;
   mcrb_drive_t adrv, sdrv;
   mcrb_ratio_t ratio;
   logic [7:0]  seed = 8'h2b;
   logic [7:0]  ra [6] = '{8'h43, 8'h47, 8'h4b, 8'h50, 8'h51, 8'h52};
   logic [7:0]  rv [6] = '{8'h03, 8'h2a, 8'h00, 8'h15, 8'h15, 8'h00};
   int          error_cnt = 0;
   int          checks = 0;

   always #5 clk_in = ~clk_in;

   mcrb_main uut (.clk_in(clk_in), .srst_in(srst_in), .req_in(req), .rdata_out(rdata),
      .rvalid_out(rvalid), .transmit_gate_pin_in(gate), .mon_in(mon),
      .analog_powerdown_out(apd), .aux_pin_dir_out(dir), .aux_pin_drive_out(adrv),
      .serial_out_drive_out(sdrv), .crossing_soft_reset_out(csr), .crossing_ratio_out(ratio),
      .aux_pin0_sel_out(s0), .aux_pin1_sel_out(s1), .aux_pair_sel_out(sp));

   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function automatic logic [7:0] stat(input mcrb_mon_t m);
      return {m.halt, 1'b0, m.recovered_idle, m.lane_align_seen, m.value};
   endfunction : stat

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk_in);
      req.wr = 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge clk_in);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk_in);
      req.rd = 1'b0;
      chk({7'h0, rvalid}, 8'h01);
      chk(rdata & m, e & m);
   endtask : rd_chk

   task automatic drv_chk(input mcrb_drive_t g, input logic [1:0] c);
      chk({6'h0, g.code}, {6'h0, c});
      chk({4'h0, g.slew}, 8'h01 << c);
   endtask : drv_chk

   task test_done;
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   initial
   begin
      #50000;
      error_cnt++;
      test_done;
   end

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial
   begin
      repeat (12) @(negedge clk_in);
      srst_in = 1'b0;
      repeat (2) @(negedge clk_in);
      chk({7'h0, apd}, 8'h01);
      chk({6'h0, dir}, 8'h02);
      drv_chk(adrv, 2'h2);
      drv_chk(sdrv, 2'h2);
      for (int i = 0; i < 6; i++)
         rd_chk(ra[i], rv[i], 8'hff);
      wr(8'h43, 8'h00);
      gate = 1'b1;
      repeat (5) @(negedge clk_in);
      chk({7'h0, apd}, 8'h00);
      wr(8'h43, 8'h02);
      repeat (4) @(negedge clk_in);
      chk({7'h0, apd}, 8'h01);
      gate = 1'b0;
      repeat (4) @(negedge clk_in);
      chk({7'h0, apd}, 8'h00);
      wr(8'h43, 8'hfd);
      @(negedge clk_in);
      chk({7'h0, apd}, 8'h01);
      rd_chk(8'h43, 8'h01, 8'hff);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h47, {2'h0, 2'(i), 2'(i), 2'(3 - i)});
         @(negedge clk_in);
         chk({6'h0, dir}, {6'h0, 2'(i)});
         drv_chk(adrv, 2'(i));
         drv_chk(sdrv, 2'(3 - i));
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h4b, 8'h80 | 8'(i));
         chk({7'h0, csr}, 8'h01);
         chk({6'h0, ratio}, 8'(i));
         @(negedge clk_in);
         chk({7'h0, csr}, 8'h00);
         wr(8'h4b, 8'(i));
         chk({7'h0, csr}, 8'h00);
         rd_chk(8'h4b, 8'(i), 8'hff);
      end
      mon = '1;
      rd_chk(8'h54, 8'hbf, 8'hbf);
      for (int n = 0; n < 20; n++)
      begin
         for (int k = 0; k < 3; k++)
         begin
            seed = lfsr(seed);
            wr(8'h50 + 8'(k), seed);
            sel = (k == 0) ? s0 : (k == 1) ? s1 : sp;
            chk(sel, seed);
            rd_chk(8'h50 + 8'(k), seed, 8'hff);
         end
         mon = mcrb_mon_t'({seed[6:0], lfsr(seed)});
         wr(8'h54, ~seed);
         rd_chk(8'h54, stat(mon), 8'hbf);
         rd_chk(8'h55, mon.flag_bits, 8'hff);
      end
      rd_chk(8'h60, 8'h00, 8'hff);
      test_done;
   end
endmodule : main_control_register_bank_test
